// File: include/dbu_regs.vh
// debug breakpoint unit register indices, field positions and reset values
`ifndef DBU_REGS_VH
`define DBU_REGS_VH

// ----------------------------------------------------------------------
// debug register indices (5-bit index space)
// ----------------------------------------------------------------------
`define DBU_IDX_ADDR_ATTR_TRIG  5'h06
`define DBU_IDX_DEBUG_MEM_ATTR  5'h05
`define DBU_IDX_CONFIG          5'h00
`define DBU_IDX_PC_BREAK_BASE   5'h08
`define DBU_IDX_PC_BREAK_MASK   5'h09
`define DBU_IDX_PC_BREAK_ONE    5'h18
`define DBU_IDX_PC_BREAK_TWO    5'h1a
`define DBU_IDX_PC_BREAK_THREE  5'h1b

// ----------------------------------------------------------------------
// configuration register fields
// ----------------------------------------------------------------------
`define DBU_CFG_BRK_IRQ_BIT     0
`define DBU_CFG_PC_EN_LSB       1
`define DBU_CFG_RST             8'h00

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define DBU_ATTR_RST            8'h05
`define DBU_TRIG_RST            16'h0005
`define DBU_PC_RST              32'h00000000
`define DBU_MASK_RST            32'h00000000

`endif

// File: design/dbu_pc_match.v
// one program-counter comparator with optional mask
module dbu_pc_match #(
   parameter WIDTH = 32
) (
   input  wire [WIDTH-1:0] pc,
   input  wire [WIDTH-1:0] target,
   input  wire [WIDTH-1:0] mask,
   input  wire             enable,
   output wire             hit
);
   // a set mask bit excludes that bit from the compare
   assign hit = enable & (((pc ^ target) & ~mask) == {WIDTH{1'b0}});
endmodule // dbu_pc_match

// File: design/dbu_debug_unit.v
// debug breakpoint unit: debug register file, breakpoints, status combine
`include "dbu_regs.vh"

// Function
// [RL1] debug command address and attributes never touch breakpoint registers
// [RL2] hidden memory address register loads automatically during memory commands
// [RL3] 8-bit debug memory attribute register lives at index 0x05
// [RL4] attribute register uses trigger low-byte layout, drives all debug accesses
// [RL5] three extra pc breakpoint registers at indices 0x18, 0x1a, 0x1b
// [RL6] original pc breakpoint is masked; extra ones need an exact match
// [RL7] break request halts core or, when configured, raises debug interrupt
// [RL8] combined status output is the AND of four processor status lines
// [RL9] debugger reads combined status low as running, high as halted
// [RL10] earlier breakpoint and trigger registers keep their old behaviour
// [RL11] debug write command carries register index decoded to select register
module dbu_debug_unit #(
   parameter AW = 32,
   parameter DW = 32
) (
   input  wire          mclk,
   input  wire          reset,
   // debug command port from the background debug serial engine
   input  wire          cmd_wr_reg,
   input  wire          cmd_rd_reg,
   input  wire [4:0]    debug_reg_index,
   input  wire [DW-1:0] cmd_wdata,
   output reg  [DW-1:0] cmd_rdata,
   output reg           cmd_rvalid,
   input  wire          cmd_mem_start,
   input  wire [AW-1:0] cmd_mem_addr,
   input  wire          cmd_mem_done,
   output reg  [AW-1:0] dbg_mem_addr,
   output reg  [7:0]    dbg_mem_attr,
   output reg           dbg_mem_active,
   // core side
   input  wire [AW-1:0] core_pc,
   input  wire          core_pc_valid,
   input  wire [3:0]    proc_status_lines,
   input  wire          break_request_in,
   output reg           halt_req,
   output reg           debug_irq,
   output reg  [3:0]    pc_hit,
   output reg           combined_status_out
);

   // ----------------------------------------------------------------------
   // register state
   // ----------------------------------------------------------------------
   reg  [7:0]    cfg_r;
   reg  [7:0]    debug_mem_attr_r;
   reg  [15:0]   addr_attr_trigger_r;
   reg  [AW-1:0] pc_break_base_r;
   reg  [AW-1:0] pc_break_mask_r;
   reg  [AW-1:0] pc_break_one_r;
   reg  [AW-1:0] pc_break_two_r;
   reg  [AW-1:0] pc_break_three_r;
   reg  [AW-1:0] mem_addr_r;
   reg  [1:0]    brk_sync_r;
   reg  [3:0]    pst_meta_r;
   reg  [3:0]    pst_sync_r;
   reg           brk_prev_r;
   wire [3:0]    hit_nxt;
   wire          brk_rise;

   // decode helper used by both the write and read paths
   function sel;
      input [4:0] idx;
      input [4:0] want;
      begin
         sel = (idx == want);
      end
   endfunction

   // ----------------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------------
   // the memory-command address is a separate hidden register so a debug
   // memory command can never disturb breakpoint comparators
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         cfg_r               <= `DBU_CFG_RST;
         debug_mem_attr_r    <= `DBU_ATTR_RST;
         addr_attr_trigger_r <= `DBU_TRIG_RST;
         pc_break_base_r     <= `DBU_PC_RST;
         pc_break_mask_r     <= `DBU_MASK_RST;
         pc_break_one_r      <= `DBU_PC_RST;
         pc_break_two_r      <= `DBU_PC_RST;
         pc_break_three_r    <= `DBU_PC_RST;
      end else if (cmd_wr_reg) begin // RL11
         if (sel(debug_reg_index, `DBU_IDX_CONFIG))
            cfg_r <= cmd_wdata[7:0];
         if (sel(debug_reg_index, `DBU_IDX_DEBUG_MEM_ATTR))
            debug_mem_attr_r <= cmd_wdata[7:0]; // RL3
         if (sel(debug_reg_index, `DBU_IDX_ADDR_ATTR_TRIG))
            addr_attr_trigger_r <= cmd_wdata[15:0]; // RL10
         if (sel(debug_reg_index, `DBU_IDX_PC_BREAK_BASE))
            pc_break_base_r <= cmd_wdata[AW-1:0]; // RL10
         if (sel(debug_reg_index, `DBU_IDX_PC_BREAK_MASK))
            pc_break_mask_r <= cmd_wdata[AW-1:0];
         if (sel(debug_reg_index, `DBU_IDX_PC_BREAK_ONE))
            pc_break_one_r <= cmd_wdata[AW-1:0]; // RL5
         if (sel(debug_reg_index, `DBU_IDX_PC_BREAK_TWO))
            pc_break_two_r <= cmd_wdata[AW-1:0]; // RL5
         if (sel(debug_reg_index, `DBU_IDX_PC_BREAK_THREE))
            pc_break_three_r <= cmd_wdata[AW-1:0]; // RL5
      end
   end

   // ----------------------------------------------------------------------
   // register reads (pc breakpoint registers are write only, read zero)
   // ----------------------------------------------------------------------
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         cmd_rdata  <= {DW{1'b0}};
         cmd_rvalid <= 1'b0;
      end else begin
         cmd_rvalid <= cmd_rd_reg;
         if (cmd_rd_reg) begin
            if (sel(debug_reg_index, `DBU_IDX_DEBUG_MEM_ATTR))
               cmd_rdata <= {{(DW-8){1'b0}}, debug_mem_attr_r};
            else if (sel(debug_reg_index, `DBU_IDX_CONFIG))
               cmd_rdata <= {{(DW-8){1'b0}}, cfg_r};
            else if (sel(debug_reg_index, `DBU_IDX_ADDR_ATTR_TRIG))
               cmd_rdata <= {{(DW-16){1'b0}}, addr_attr_trigger_r};
            else
               cmd_rdata <= {DW{1'b0}};
         end
      end
   end

   // ----------------------------------------------------------------------
   // debug memory command path
   // ----------------------------------------------------------------------
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         mem_addr_r     <= {AW{1'b0}};
         dbg_mem_addr   <= {AW{1'b0}};
         dbg_mem_attr   <= 8'h00;
         dbg_mem_active <= 1'b0;
      end else begin
         if (cmd_mem_start) begin
            mem_addr_r     <= cmd_mem_addr; // RL2
            dbg_mem_addr   <= cmd_mem_addr; // RL1
            dbg_mem_attr   <= debug_mem_attr_r; // RL4
            dbg_mem_active <= 1'b1;
         end else if (cmd_mem_done) begin
            dbg_mem_active <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------------
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         brk_sync_r <= 2'b00;
         brk_prev_r <= 1'b0;
         pst_meta_r <= 4'h0;
         pst_sync_r <= 4'h0;
      end else begin
         brk_sync_r <= {brk_sync_r[0], break_request_in};
         brk_prev_r <= brk_sync_r[1];
         pst_meta_r <= proc_status_lines;
         pst_sync_r <= pst_meta_r;
      end
   end

   assign brk_rise = brk_sync_r[1] & ~brk_prev_r;

   // ----------------------------------------------------------------------
   // pc comparators
   // ----------------------------------------------------------------------
   dbu_pc_match #(.WIDTH(AW)) u_pc0 (
      .pc     (core_pc),
      .target (pc_break_base_r),
      .mask   (pc_break_mask_r), // RL6
      .enable (core_pc_valid & cfg_r[`DBU_CFG_PC_EN_LSB]),
      .hit    (hit_nxt[0])
   );
   dbu_pc_match #(.WIDTH(AW)) u_pc1 (
      .pc     (core_pc),
      .target (pc_break_one_r),
      .mask   ({AW{1'b0}}), // RL6
      .enable (core_pc_valid & cfg_r[`DBU_CFG_PC_EN_LSB+1]),
      .hit    (hit_nxt[1])
   );
   dbu_pc_match #(.WIDTH(AW)) u_pc2 (
      .pc     (core_pc),
      .target (pc_break_two_r),
      .mask   ({AW{1'b0}}),
      .enable (core_pc_valid & cfg_r[`DBU_CFG_PC_EN_LSB+2]),
      .hit    (hit_nxt[2])
   );
   dbu_pc_match #(.WIDTH(AW)) u_pc3 (
      .pc     (core_pc),
      .target (pc_break_three_r),
      .mask   ({AW{1'b0}}),
      .enable (core_pc_valid & cfg_r[`DBU_CFG_PC_EN_LSB+3]),
      .hit    (hit_nxt[3])
   );

   // ----------------------------------------------------------------------
   // break outcome and status
   // ----------------------------------------------------------------------
   // debug_irq is a one-cycle pulse; halt_req pulses on a break request when cfg_r bit 0 is clear and stays high while a pc hit lasts; the core latches them
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         pc_hit              <= 4'h0;
         halt_req            <= 1'b0;
         debug_irq           <= 1'b0;
         combined_status_out <= 1'b0;
      end else begin
         pc_hit <= hit_nxt;
         if (cfg_r[`DBU_CFG_BRK_IRQ_BIT]) begin
            halt_req  <= |hit_nxt;
            debug_irq <= brk_rise; // RL7
         end else begin
            halt_req  <= brk_rise | (|hit_nxt); // RL7
            debug_irq <= 1'b0;
         end
         // high means halted, low means running
         combined_status_out <= &pst_sync_r; // RL8 RL9
      end
   end

endmodule // dbu_debug_unit

// File: testbench/dbu_props.sv
// port assertions for the debug breakpoint unit
module dbu_props (
   input wire        mclk,
   input wire        reset,
   input wire        cmd_rd_reg,
   input wire [4:0]  debug_reg_index,
   input wire [31:0] cmd_rdata,
   input wire        cmd_rvalid,
   input wire        cmd_mem_start,
   input wire [31:0] cmd_mem_addr,
   input wire        cmd_mem_done,
   input wire [31:0] dbg_mem_addr,
   input wire        dbg_mem_active,
   input wire        core_pc_valid,
   input wire [3:0]  proc_status_lines,
   input wire        break_request_in,
   input wire        halt_req,
   input wire        debug_irq,
   input wire [3:0]  pc_hit,
   input wire        combined_status_out
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (reset);
   property p_rv; cmd_rd_reg |=> cmd_rvalid; endproperty
   a_rv: assert property (p_rv) else $error("read valid missing");
   property p_wo; cmd_rd_reg && debug_reg_index[4:3] == 2'h3 |=> cmd_rdata == 32'h0; endproperty
   a_wo: assert property (p_wo) else $error("high index read not zero");
   property p_ma; cmd_mem_start |=> dbg_mem_active && dbg_mem_addr == $past(cmd_mem_addr); endproperty
   a_ma: assert property (p_ma) else $error("memory address not loaded");
   property p_md; cmd_mem_done && !cmd_mem_start |=> !dbg_mem_active; endproperty
   a_md: assert property (p_md) else $error("memory command not ended");
   property p_bk; $rose(break_request_in) |-> ##[2:4] (halt_req || debug_irq); endproperty
   a_bk: assert property (p_bk) else $error("break request ignored");
   property p_nh; !core_pc_valid |=> pc_hit == 4'h0; endproperty
   a_nh: assert property (p_nh) else $error("hit without pc");
   property p_hh; pc_hit != 4'h0 |-> halt_req; endproperty
   a_hh: assert property (p_hh) else $error("hit without halt");
   property p_st; $stable(proc_status_lines) [*5] |-> combined_status_out == &proc_status_lines; endproperty
   a_st: assert property (p_st) else $error("combined status wrong");
endmodule // dbu_props

// File: testbench/dbu_probe.sv
// debugger probe model: reads the combined status pin
module dbu_probe (
   input  wire combined_status_out,
   output wire probe_halted
);
   timeunit 1ns;
   timeprecision 1ns;
   // high means halted, low means running
   assign probe_halted = combined_status_out;
endmodule // dbu_probe

// File: testbench/dbu_debug_unit_test.sv
// self-checking bench for the debug breakpoint unit
module dbu_debug_unit_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        mclk = 0, reset = 1, cmd_wr_reg = 0, cmd_rd_reg = 0;
   logic        cmd_mem_start = 0, cmd_mem_done = 0, core_pc_valid = 0, break_request_in = 0;
   logic [4:0]  debug_reg_index = 5'h00;
   logic [31:0] cmd_wdata = 32'h0, cmd_mem_addr = 32'h0, core_pc = 32'h0;
   logic [3:0]  proc_status_lines = 4'h0;
   wire  [31:0] cmd_rdata, dbg_mem_addr;
   wire  [7:0]  dbg_mem_attr;
   wire  [3:0]  pc_hit;
   wire         cmd_rvalid, dbg_mem_active, halt_req, debug_irq;
   wire         combined_status_out, probe_halted;
   int          errors = 0, compares = 0, i;
   always #4 mclk = ~mclk;
   dbu_debug_unit i_dut (.*);
   dbu_probe i_probe (.*);
   task automatic stop_test;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(negedge mclk);
      cmd_wr_reg = 1;
      debug_reg_index = a;
      cmd_wdata = d;
      @(negedge mclk);
      cmd_wr_reg = 0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(negedge mclk);
      cmd_rd_reg = 1;
      debug_reg_index = a;
      @(negedge mclk);
      cmd_rd_reg = 0;
      chk(cmd_rdata, e);
      chk(cmd_rvalid, 32'h1);
   endtask
   task automatic pc(input logic [31:0] p, input logic [3:0] e);
      @(negedge mclk);
      core_pc = p;
      core_pc_valid = 1;
      @(negedge mclk);
      core_pc_valid = 0;
      chk({halt_req, pc_hit}, {|e, e});
   endtask
   task automatic brk(input logic irq);
      wr(5'h00, {31'h0, irq});
      break_request_in = 1;
      for (i = 0; i < 8 && !(irq ? debug_irq : halt_req); i++) @(negedge mclk);
      chk({halt_req, debug_irq}, {!irq, irq});
      if (i == 8) stop_test();
      break_request_in = 0;
   endtask
   initial begin
      repeat (5) @(negedge mclk);
      reset = 0;
      rd(5'h05, 32'h05);
      wr(5'h05, 32'hffff_ffa5);
      wr(5'h0f, 32'h3c);
      rd(5'h05, 32'ha5);
      rd(5'h0f, 32'h0);
      wr(5'h18, 32'h2000);
      wr(5'h1a, 32'h3000);
      wr(5'h1b, 32'h4000);
      rd(5'h1a, 32'h0);
      wr(5'h08, 32'h1000);
      wr(5'h09, 32'hf);
      $display("registers done");
      @(negedge mclk);
      cmd_mem_start = 1;
      cmd_mem_addr = 32'h8000_0010;
      @(negedge mclk);
      cmd_mem_start = 0;
      chk(dbg_mem_addr, 32'h8000_0010);
      chk({dbg_mem_active, dbg_mem_attr}, 32'h1a5);
      cmd_mem_done = 1;
      @(negedge mclk);
      cmd_mem_done = 0;
      chk(dbg_mem_active, 32'h0);
      $display("memory command done");
      wr(5'h00, 32'h02);
      pc(32'h2000, 4'h0);
      wr(5'h00, 32'h1e);
      pc(32'h1008, 4'h1);
      pc(32'h2000, 4'h2);
      pc(32'h2004, 4'h0);
      pc(32'h3000, 4'h4);
      pc(32'h4000, 4'h8);
      $display("pc breakpoints done");
      brk(1'b0);
      brk(1'b1);
      $display("break request done");
      for (i = 0; i < 2; i++) begin
         proc_status_lines = i ? 4'h7 : 4'hf;
         repeat (5) @(negedge mclk);
         chk(probe_halted, !i);
      end
      $display("status done");
      wr(5'h05, 32'h5a);
      reset = 1;
      @(negedge mclk);
      reset = 0;
      chk({halt_req, debug_irq, pc_hit}, 32'h0);
      rd(5'h05, 32'h05);
      $display("mid-run reset done");
      stop_test();
   end
endmodule // dbu_debug_unit_test
bind dbu_debug_unit dbu_props i_props (.*);
